// ==== diag_bus_edge_irq_pkg.sv ====
// What this block does
// - four channel bytes in one 32-bit word
// - chosen edge sets channel event flag
// - reading control word clears event flags
// - software writes never change event flags
// - polarity zero rising, one falling edge
// - bit pick chooses one of eight bits
// - bus pick: baseband 0/1, radio 0/1
// - enabled flag rise raises the request
`default_nettype none

package diag_bus_edge_irq_pkg;

  // ==========================================================
  // channel layout
  localparam int NUM_CHAN     = 4;
  localparam int CHAN_STRIDE  = 8;
  localparam int CFG_W        = 7;
  localparam int POS_FLAG     = 7;
  localparam int POS_POLARITY = 6;
  localparam int POS_BIT_LO   = 3;
  localparam int POS_BIT_HI   = 5;
  localparam int POS_BUS_LO   = 1;
  localparam int POS_BUS_HI   = 2;
  localparam int POS_ENABLE   = 0;

  // ==========================================================
  // register map, byte addresses
  localparam logic [31:0] ADDR_CTRL_STATUS = 32'h4000_0204;
  localparam logic [31:0] ADDR_IRQ_STATUS  = 32'h4000_0208;
  localparam logic [31:0] ADDR_IRQ_MASK    = 32'h4000_020C;

  // ==========================================================
  // reset values
  localparam logic [CFG_W-1:0]    RST_CFG   = 7'h00;
  localparam logic [NUM_CHAN-1:0] RST_FLAGS = 4'h0;
  localparam logic [NUM_CHAN-1:0] RST_MASK  = 4'h0;
  localparam logic [31:0]         RST_DATA  = 32'h0000_0000;

endpackage : diag_bus_edge_irq_pkg

`default_nettype wire

// ==== diag_bus_edge_irq.sv ====
`timescale 1ns/1ps
`default_nettype none

module diag_bus_edge_irq
  import diag_bus_edge_irq_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic        PREADY,
  output var  logic [31:0] PRDATA,
  output var  logic        PSLVERR,
  input  wire logic [7:0]  BASEBAND_PROBE_BUS0,
  input  wire logic [7:0]  BASEBAND_PROBE_BUS1,
  input  wire logic [7:0]  RADIO_PROBE_BUS0,
  input  wire logic [7:0]  RADIO_PROBE_BUS1,
  output var  logic        DIAG_EVENT_IRQ,
  output var  logic        IRQ
);

  // ==========================================================
  // reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [NUM_CHAN-1:0][CFG_W-1:0] cfg;
    logic [NUM_CHAN-1:0]            flag;
    logic [NUM_CHAN-1:0]            prev;
    logic [NUM_CHAN-1:0]            pend;
    logic [NUM_CHAN-1:0]            imask;
    logic                           ready;
    logic [31:0]                    rdata;
    logic                           slverr;
    logic                           pulse;
    logic                           irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ==========================================================
  // probe selection and edge detection
  logic [3:0][7:0]      probe;
  logic [NUM_CHAN-1:0]  cur;
  logic [NUM_CHAN-1:0]  hit;
  logic [NUM_CHAN-1:0]  chan_en;

  assign probe = {RADIO_PROBE_BUS1, RADIO_PROBE_BUS0, BASEBAND_PROBE_BUS1, BASEBAND_PROBE_BUS0};

  // retargeting a channel can show one spurious edge: prev still holds
  // the old source bit for one cycle
  for (genvar n = 0; n < NUM_CHAN; n++) begin : g_chan
    logic [1:0] bus_pick;
    logic [2:0] bit_pick;
    assign bus_pick = s_q.cfg[n][POS_BUS_HI:POS_BUS_LO];
    assign bit_pick = s_q.cfg[n][POS_BIT_HI:POS_BIT_LO];
    assign chan_en[n] = s_q.cfg[n][POS_ENABLE];
    assign cur[n]   = probe[bus_pick][bit_pick];
    assign hit[n]   = s_q.cfg[n][POS_POLARITY] ? (s_q.prev[n] & ~cur[n])
                                               : (cur[n] & ~s_q.prev[n]);
  end

  // ==========================================================
  // bus decode
  logic acc_start;
  logic done;
  logic hit_ctrl;
  logic hit_istat;
  logic hit_imask;
  logic mapped;
  logic rd_ctrl_done;
  logic [31:0] ctrl_word;

  assign acc_start    = PSEL & PENABLE & ~s_q.ready;
  assign done         = PSEL & PENABLE & s_q.ready;
  assign hit_ctrl     = (PADDR == ADDR_CTRL_STATUS);
  assign hit_istat    = (PADDR == ADDR_IRQ_STATUS);
  assign hit_imask    = (PADDR == ADDR_IRQ_MASK);
  assign mapped       = hit_ctrl | hit_istat | hit_imask;
  assign rd_ctrl_done = done & ~PWRITE & hit_ctrl;

  always_comb begin
    ctrl_word = RST_DATA;
    for (int n = 0; n < NUM_CHAN; n++) begin
      ctrl_word[n*CHAN_STRIDE +: CFG_W]          = s_q.cfg[n];
      ctrl_word[n*CHAN_STRIDE + POS_FLAG]        = s_q.flag[n];
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    s_d       = s_q;
    s_d.prev  = cur;
    s_d.pulse = 1'b0;

    // one wait state keeps every bus output registered
    s_d.ready = acc_start;
    if (acc_start) begin
      s_d.slverr = ~mapped;
      s_d.rdata  = RST_DATA;
      if (!PWRITE && hit_ctrl) begin
        s_d.rdata = ctrl_word;
      end else if (!PWRITE && hit_istat) begin
        s_d.rdata[NUM_CHAN-1:0] = s_q.pend;
      end else if (!PWRITE && hit_imask) begin
        s_d.rdata[NUM_CHAN-1:0] = s_q.imask;
      end
    end else if (done) begin
      s_d.slverr = 1'b0;
    end

    // only the flags that were returned are cleared, so a flag set
    // between capture and completion survives
    if (rd_ctrl_done) begin
      for (int n = 0; n < NUM_CHAN; n++) begin
        if (s_q.rdata[n*CHAN_STRIDE + POS_FLAG]) begin
          s_d.flag[n] = 1'b0;
        end
      end
    end

    if (done && PWRITE && hit_ctrl) begin
      for (int n = 0; n < NUM_CHAN; n++) begin
        s_d.cfg[n] = PWDATA[n*CHAN_STRIDE +: CFG_W];
      end
    end
    if (done && PWRITE && hit_imask) begin
      s_d.imask = PWDATA[NUM_CHAN-1:0];
    end
    if (done && PWRITE && hit_istat) begin
      s_d.pend = s_q.pend & ~PWDATA[NUM_CHAN-1:0];
    end

    // detection last so a set beats a same-cycle clear
    for (int n = 0; n < NUM_CHAN; n++) begin
      if (hit[n]) begin
        s_d.flag[n] = 1'b1;
        if (s_q.cfg[n][POS_ENABLE]) begin
          s_d.pend[n] = 1'b1;
          s_d.pulse   = 1'b1;
        end
      end
    end

    s_d.irq = |(s_d.pend & s_d.imask);
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      s_q.cfg    <= {NUM_CHAN{RST_CFG}};
      s_q.flag   <= RST_FLAGS;
      s_q.prev   <= RST_FLAGS;
      s_q.pend   <= RST_FLAGS;
      s_q.imask  <= RST_MASK;
      s_q.ready  <= 1'b0;
      s_q.rdata  <= RST_DATA;
      s_q.slverr <= 1'b0;
      s_q.pulse  <= 1'b0;
      s_q.irq    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign PREADY         = s_q.ready;
  assign PRDATA         = s_q.rdata;
  assign PSLVERR        = s_q.slverr;
  assign DIAG_EVENT_IRQ = s_q.pulse;
  assign IRQ            = s_q.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_read_setup;
    PSEL && PENABLE && !PREADY && !PWRITE && hit_ctrl;
  endsequence

  sequence s_ctrl_read_done;
    PSEL && PENABLE && PREADY && !PWRITE && hit_ctrl;
  endsequence

  sequence s_quiet;
    hit == 4'h0;
  endsequence

  apb_ready_wait_a : assert property (acc_start |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle after access start");

  layout_readback_a : assert property (s_ctrl_read_setup |=>
      PRDATA == $past(ctrl_word) && PRDATA[7] == $past(s_q.flag[0])
      && PRDATA[30] == $past(s_q.cfg[3][POS_POLARITY]))
    else $error("control word readback layout wrong");

  flag_set_a : assert property (|hit |=> (s_q.flag & $past(hit)) == $past(hit))
    else $error("detected edge did not set flag");

  read_clear_a : assert property (s_ctrl_read_setup ##1 (s_ctrl_read_done and s_quiet)
      |=> (s_q.flag & {$past(PRDATA[31]), $past(PRDATA[23]), $past(PRDATA[15]), $past(PRDATA[7])}) == 4'h0)
    else $error("returned flag survived a control read");

  flag_fall_a : assert property (|($past(s_q.flag) & ~s_q.flag) |-> $past(rd_ctrl_done))
    else $error("flag cleared without a control read");

  rise_edge_a : assert property (!s_q.cfg[0][POS_POLARITY] && cur[0] && !s_q.prev[0]
      |=> s_q.flag[0])
    else $error("rising edge missed on channel 0");

  fall_edge_a : assert property (s_q.cfg[0][POS_POLARITY] && !cur[0] && s_q.prev[0]
      |=> s_q.flag[0])
    else $error("falling edge missed on channel 0");

  bit_pick_a : assert property (s_q.cfg[1][POS_BUS_HI:POS_BUS_LO] == 2'h2
      |-> cur[1] == RADIO_PROBE_BUS0[s_q.cfg[1][POS_BIT_HI:POS_BIT_LO]])
    else $error("channel 1 bit source wrong");

  bus_pick_a : assert property (s_q.cfg[2][POS_BUS_HI:POS_BUS_LO] == 2'h1
      |-> cur[2] == BASEBAND_PROBE_BUS1[s_q.cfg[2][POS_BIT_HI:POS_BIT_LO]])
    else $error("channel 2 bus source wrong");

  masked_pulse_a : assert property (|(hit & ~{s_q.cfg[3][0], s_q.cfg[2][0], s_q.cfg[1][0], s_q.cfg[0][0]})
      && !(|(hit & {s_q.cfg[3][0], s_q.cfg[2][0], s_q.cfg[1][0], s_q.cfg[0][0]}))
      |=> !DIAG_EVENT_IRQ)
    else $error("request raised by a disabled channel");

  enabled_pulse_a : assert property (hit[0] && s_q.cfg[0][POS_ENABLE]
      |=> DIAG_EVENT_IRQ && s_q.pend[0])
    else $error("enabled channel raised no request");

  irq_level_a : assert property (hit[2] && s_q.cfg[2][POS_ENABLE] && s_q.imask[2]
      |=> IRQ)
    else $error("level request low after an enabled unmasked event");

  // ==========================================================
  // bus answer checks
  sequence s_ctrl_write_done;
    PSEL && PENABLE && PREADY && PWRITE && hit_ctrl;
  endsequence

  sequence s_stat_write_done;
    PSEL && PENABLE && PREADY && PWRITE && hit_istat;
  endsequence

  sequence s_stat_read_setup;
    PSEL && PENABLE && !PREADY && !PWRITE && hit_istat;
  endsequence

  sequence s_mask_read_setup;
    PSEL && PENABLE && !PREADY && !PWRITE && hit_imask;
  endsequence

  apb_answer_a : assert property (PREADY |-> $past(acc_start))
    else $error("ready raised without an access start");

  err_with_ready_a : assert property (PSLVERR |-> PREADY)
    else $error("error flag raised outside a completion");

  unmapped_err_a : assert property (acc_start && !mapped |=> PSLVERR && PRDATA == RST_DATA)
    else $error("unmapped access not refused");

  mapped_ok_a : assert property (acc_start && mapped |=> !PSLVERR)
    else $error("mapped access flagged as error");

  write_rdata_a : assert property (acc_start && PWRITE |=> PRDATA == RST_DATA)
    else $error("write returned nonzero read data");

  unmapped_quiet_a : assert property (done && !mapped |=> $stable(s_q.cfg) && $stable(s_q.imask))
    else $error("unmapped access changed a register");

  // ==========================================================
  // register field checks
  cfg_write_a : assert property (s_ctrl_write_done |=> s_q.cfg[1] == $past(PWDATA[14:8])
      && s_q.cfg[3] == $past(PWDATA[30:24]))
    else $error("control write landed in the wrong field");

  write_keeps_flags_a : assert property ((s_ctrl_write_done and s_quiet) |=> $stable(s_q.flag))
    else $error("software write changed an event flag");

  flag_source_a : assert property (!s_q.flag[0] && !hit[0] |=> !s_q.flag[0])
    else $error("flag 0 set without a detected edge");

  prev_track_a : assert property (1'b1 |=> s_q.prev == $past(cur))
    else $error("edge history does not follow the picked bit");

  bus0_pick_a : assert property (s_q.cfg[0][POS_BUS_HI:POS_BUS_LO] == 2'h0
      |-> cur[0] == BASEBAND_PROBE_BUS0[s_q.cfg[0][POS_BIT_HI:POS_BIT_LO]])
    else $error("channel 0 bit source wrong");

  bus3_pick_a : assert property (s_q.cfg[3][POS_BUS_HI:POS_BUS_LO] == 2'h3
      |-> cur[3] == RADIO_PROBE_BUS1[s_q.cfg[3][POS_BIT_HI:POS_BIT_LO]])
    else $error("channel 3 bit source wrong");

  // ==========================================================
  // request checks
  idle_pulse_a : assert property (hit == 4'h0 |=> !DIAG_EVENT_IRQ)
    else $error("request pulse without a detected edge");

  pulse_cause_a : assert property (DIAG_EVENT_IRQ |-> $past(|(hit & chan_en)))
    else $error("request pulse without an enabled detection");

  pend_set_a : assert property (hit[1] && chan_en[1] |=> s_q.pend[1])
    else $error("enabled channel 1 edge left pending clear");

  pend_only_enabled_a : assert property (!s_q.pend[2] && !(hit[2] && chan_en[2]) |=> !s_q.pend[2])
    else $error("pending bit set by a disabled channel");

  stat_w1c_a : assert property ((s_stat_write_done and s_quiet)
      |=> (s_q.pend & $past(PWDATA[3:0])) == 4'h0)
    else $error("pending bit survived a write of one");

  stat_readback_a : assert property (s_stat_read_setup |=> PRDATA == {28'h0, $past(s_q.pend)})
    else $error("pending register readback wrong");

  mask_readback_a : assert property (s_mask_read_setup |=> PRDATA == {28'h0, $past(s_q.imask)})
    else $error("mask register readback wrong");

  irq_gated_a : assert property ((s_q.pend & s_q.imask) == 4'h0 && (hit & chan_en) == 4'h0
      && !(done && PWRITE && hit_imask) |=> !IRQ)
    else $error("level request high with nothing pending");

endmodule // diag_bus_edge_irq

`default_nettype wire

// ==== probe_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// probe bus source, levels move only on the clock edge
module probe_model (
  input  wire logic       clk,
  input  wire logic       set_en,
  input  wire logic [1:0] set_bus,
  input  wire logic [2:0] set_bit,
  input  wire logic       set_val,
  output var  logic [7:0] bb0,
  output var  logic [7:0] bb1,
  output var  logic [7:0] rd0,
  output var  logic [7:0] rd1
);
  logic [7:0] bus_q [4] = '{default: 8'h00};

  always_ff @(posedge clk) begin
    if (set_en) begin
      bus_q[set_bus][set_bit] <= set_val;
    end
  end

  assign bb0 = bus_q[0];
  assign bb1 = bus_q[1];
  assign rd0 = bus_q[2];
  assign rd1 = bus_q[3];
endmodule // probe_model

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module tb_top;
  import diag_bus_edge_irq_pkg::*;
  localparam logic [31:0] A = ADDR_CTRL_STATUS;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        set_en = 0, set_val = 0, pready, pslverr, dirq, irq, err;
  logic [1:0]  set_bus = '0;
  logic [2:0]  set_bit = '0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rdata;
  logic [7:0]  bb0, bb1, rd0, rd1;
  int          miscompares = 0, n_checks = 0, pulses = 0;

  diag_bus_edge_irq i_dut (.CLOCK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .BASEBAND_PROBE_BUS0(bb0), .BASEBAND_PROBE_BUS1(bb1), .RADIO_PROBE_BUS0(rd0),
    .RADIO_PROBE_BUS1(rd1), .DIAG_EVENT_IRQ(dirq), .IRQ(irq));
  probe_model i_probe (.clk(clk), .set_en(set_en), .set_bus(set_bus), .set_bit(set_bit),
    .set_val(set_val), .bb0(bb0), .bb1(bb1), .rd0(rd0), .rd1(rd1));

  initial begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dirq === 1'b1) pulses++;
  end

  // ==========================================
  // bus and probe tasks
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(0, a, '0);
    `CHK(rdata, e)
  endtask

  task automatic drv(input int b, input int i, input logic v);
    @(posedge clk);
    set_en <= 1;
    set_bus <= 2'(b);
    set_bit <= 3'(i);
    set_val <= v;
    @(posedge clk);
    set_en <= 0;
  endtask

  // channel n watches bus n, bit n+3
  function automatic logic [31:0] cfg(input int n, input logic pol, input logic en);
    return {24'h0, 1'b0, pol, 3'(n + 3), 2'(n), en} << (8 * n);
  endfunction

  // ==========================================
  // scenarios
  task automatic t_edges;
    logic        pol;
    logic [31:0] w;
    for (int n = 0; n < 4; n++) begin
      pol = n[0];
      w = cfg(n, pol, 1);
      drv(n, n + 3, pol);
      apb(1, A, w);
      repeat (3) @(posedge clk);
      apb(0, A, '0);
      pulses = 0;
      drv(n ^ 1, n + 3, !pol);
      repeat (3) @(posedge clk);
      rd(A, w);
      drv(n, n + 3, !pol);
      repeat (3) @(posedge clk);
      rd(A, w | (32'h80 << (8 * n)));
      `CHK(pulses, 1)
      rd(A, w);
      drv(n, n + 3, pol);
      repeat (3) @(posedge clk);
      rd(A, w);
    end
    $display("edges done");
  endtask

  task automatic t_ro_mask;
    apb(1, A, cfg(0, 0, 1));
    repeat (2) @(posedge clk);
    apb(0, A, '0);
    drv(0, 3, 1);
    repeat (3) @(posedge clk);
    apb(1, A, cfg(0, 0, 1) | 32'h8080_8080);
    rd(A, cfg(0, 0, 1) | 32'h80);
    apb(1, A, cfg(2, 0, 0));
    repeat (2) @(posedge clk);
    apb(0, A, '0);
    pulses = 0;
    drv(2, 5, 1);
    repeat (3) @(posedge clk);
    rd(A, cfg(2, 0, 0) | 32'h80_0000);
    `CHK(pulses, 0)
    $display("read-only and mask done");
  endtask

  task automatic t_irq;
    apb(1, ADDR_IRQ_MASK, 32'hFFFF_FFFF);
    rd(ADDR_IRQ_MASK, 32'h0000_000F);
    apb(1, A, cfg(2, 0, 1));
    repeat (2) @(posedge clk);
    apb(1, ADDR_IRQ_STATUS, 32'h0000_000F);
    drv(2, 5, 0);
    drv(2, 5, 1);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    rd(ADDR_IRQ_STATUS, 32'h0000_0004);
    apb(1, ADDR_IRQ_STATUS, 32'h0000_0004);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(0, ADDR_IRQ_MASK + 32'h4, '0);
    `CHK(err, 1'b1)
    `CHK(rdata, 32'h0)
    $display("irq done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    rd(A, 32'h0);
    `CHK(irq, 1'b0)
    t_edges();
    t_ro_mask();
    t_irq();
    close_out();
  end
endmodule // tb_top

`default_nettype wire
